// ---- verilog/qmac_pkg.sv ----
// package for the q15 multiply-accumulate and index datapath
package qmac_pkg;
  localparam int unsigned QMAC_NUM_ACC      = 4;
  localparam int unsigned QMAC_FLAG_LSB     = 16;
  localparam int unsigned QMAC_FLAG_MSB     = 19;
  localparam int unsigned QMAC_CTRL_W       = 32;
  localparam logic [15:0] QMAC_Q15_NEG_ONE  = 16'h8000;
  localparam logic [31:0] QMAC_Q31_MAX      = 32'h7FFFFFFF;
  localparam logic [31:0] QMAC_Q31_MIN      = 32'h80000000;
  localparam logic [63:0] QMAC_ACC_RST      = 64'h0000000000000000;
  localparam logic [31:0] QMAC_CTRL_RST     = 32'h00000000;
  localparam int unsigned QMAC_IDX_LSB      = 8;
  localparam int unsigned QMAC_IDX_MSB      = 23;
  localparam int unsigned QMAC_DEC_MSB      = 7;

  typedef enum logic [3:0] {
    QMAC_OP_NONE,
    QMAC_OP_MAC_LEFT_PLAIN,
    QMAC_OP_MAC_LEFT_SAT,
    QMAC_OP_MAC_RIGHT_PLAIN,
    QMAC_OP_MAC_RIGHT_SAT,
    QMAC_OP_MOVE_FROM_UPPER,
    QMAC_OP_MOVE_FROM_LOWER,
    QMAC_OP_MOVE_TO_UPPER,
    QMAC_OP_MOVE_TO_LOWER,
    QMAC_OP_INDEX_DEC
  } qmac_op_e;
endpackage : qmac_pkg

// ---- verilog/qmac_q15_mul.sv ----
// q15 by q15 fractional multiplier producing a q31 intermediate
`timescale 1ns/1ns
module qmac_q15_mul
  import qmac_pkg::*;
(
  input  wire logic [15:0] op_a,
  input  wire logic [15:0] op_b,
  output logic      [31:0] prod_q31,
  output logic             prod_sat
);
  logic signed [31:0] raw_prod;

  always_comb begin
    raw_prod = $signed(op_a) * $signed(op_b);
    prod_sat = (op_a == QMAC_Q15_NEG_ONE) && (op_b == QMAC_Q15_NEG_ONE);
    // -1 * -1 would wrap to -1 after the shift
    if (prod_sat) begin
      prod_q31 = QMAC_Q31_MAX;
    end else begin
      prod_q31 = {raw_prod[30:0], 1'b0};
    end
  end
endmodule : qmac_q15_mul

// ---- verilog/qmac_datapath.sv ----
// q15 multiply-accumulate, accumulator moves and circular index decrement
`timescale 1ns/1ns
module qmac_datapath
  import qmac_pkg::*;
#(
  parameter int unsigned NUM_ACC = QMAC_NUM_ACC
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        op_valid,
  input  qmac_op_e         op_code,
  input  wire logic [1:0]  acc_select,
  input  wire logic [31:0] first_source_reg,
  input  wire logic [31:0] second_source_reg,
  output logic             result_valid,
  output logic      [31:0] result_data,
  output logic      [31:0] signal_proc_control_reg,
  output logic             exc_value_raised
);
  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  if (NUM_ACC != 4) begin : g_bad_acc
    $error("accumulator count must be four");
  end

  // ---------------------------------------------------------------
  // operand select and multiply
  // ---------------------------------------------------------------
  logic        is_left;
  logic        is_mac;
  logic        is_sat;
  logic [15:0] mul_a;
  logic [15:0] mul_b;
  logic [31:0] prod_q31;
  logic        prod_sat;

  assign is_left = (op_code == QMAC_OP_MAC_LEFT_PLAIN) || (op_code == QMAC_OP_MAC_LEFT_SAT);
  assign is_sat  = (op_code == QMAC_OP_MAC_LEFT_SAT) || (op_code == QMAC_OP_MAC_RIGHT_SAT);
  assign is_mac  = is_left || is_sat || (op_code == QMAC_OP_MAC_RIGHT_PLAIN);

  always_comb begin
    if (is_left) begin
      mul_a = first_source_reg[31:16];
      mul_b = second_source_reg[31:16];
    end else begin
      mul_a = first_source_reg[15:0];
      mul_b = second_source_reg[15:0];
    end
  end

  qmac_q15_mul u_mul (
    .op_a     (mul_a),
    .op_b     (mul_b),
    .prod_q31 (prod_q31),
    .prod_sat (prod_sat)
  );

  // ---------------------------------------------------------------
  // accumulate
  // ---------------------------------------------------------------
  logic [63:0] acc_q [NUM_ACC];
  logic [63:0] acc_sel;
  logic [63:0] sum;
  logic        sum_ovf;
  logic [63:0] acc_new;
  logic        flag_set;

  assign acc_sel = acc_q[acc_select];
  assign sum     = acc_sel + {{32{prod_q31[31]}}, prod_q31};
  assign sum_ovf = sum[32] != sum[31];

  always_comb begin
    acc_new  = sum;
    flag_set = 1'b0;
    if (is_sat) begin
      flag_set = prod_sat || sum_ovf;
      if (sum_ovf) begin
        // clamp chosen by bit 32: clear selects QMAC_Q31_MIN, set selects QMAC_Q31_MAX
        acc_new = sum[32] ? {{32{1'b0}}, QMAC_Q31_MAX} : {{32{1'b1}}, QMAC_Q31_MIN};
      end else begin
        acc_new = {{32{sum[31]}}, sum[31:0]};
      end
    end else begin
      // plain form reports only the product clamp
      flag_set = prod_sat;
    end
  end

  // ---------------------------------------------------------------
  // accumulator file
  // ---------------------------------------------------------------
  for (genvar g = 0; g < NUM_ACC; g++) begin : g_acc
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        acc_q[g] <= QMAC_ACC_RST;
      end else if (op_valid && acc_select == 2'(g)) begin
        if (is_mac) begin
          acc_q[g] <= acc_new;
        end else if (op_code == QMAC_OP_MOVE_TO_UPPER) begin
          acc_q[g][63:32] <= first_source_reg;
        end else if (op_code == QMAC_OP_MOVE_TO_LOWER) begin
          acc_q[g][31:0] <= first_source_reg;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // control register flags
  // ---------------------------------------------------------------
  logic [QMAC_CTRL_W-1:0] ctrl_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= QMAC_CTRL_RST;
    end else if (op_valid && is_mac && flag_set) begin
      ctrl_q[QMAC_FLAG_LSB + 32'(acc_select)] <= 1'b1;
    end
  end
  // index decrement and moves never reach the flag field
  assign signal_proc_control_reg = ctrl_q;

  // ---------------------------------------------------------------
  // general register result
  // ---------------------------------------------------------------
  logic        res_valid_q;
  logic [31:0] res_q;
  logic [31:0] res_d;
  logic        res_wr;

  always_comb begin
    res_wr = 1'b1;
    res_d  = 32'h00000000;
    case (op_code)
      QMAC_OP_MOVE_FROM_UPPER: res_d = acc_sel[63:32];
      QMAC_OP_MOVE_FROM_LOWER: res_d = acc_sel[31:0];
      QMAC_OP_INDEX_DEC: begin
        if (first_source_reg == 32'h00000000) begin
          res_d = {16'h0000, second_source_reg[QMAC_IDX_MSB:QMAC_IDX_LSB]};
        end else begin
          res_d = first_source_reg - {24'h000000, second_source_reg[QMAC_DEC_MSB:0]};
        end
      end
      default: res_wr = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      res_valid_q <= 1'b0;
    end else begin
      res_valid_q <= op_valid && res_wr;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      res_q <= 32'h00000000;
    end else if (op_valid && res_wr) begin
      res_q <= res_d;
    end
  end

  assign result_valid     = res_valid_q;
  assign result_data      = res_q;
  // value-dependent exceptions simply do not exist here
  assign exc_value_raised = 1'b0;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_mac_acc0;
    op_valid && is_mac && acc_select == 2'd0;
  endsequence

  a_sat_clamp_range: assert property (@(posedge clk) disable iff (!rstn)
    (op_valid && is_sat) |=> ($past(acc_select) != 2'd0) ||
      (acc_q[0][63:32] == {32{acc_q[0][31]}}))
    else $error("saturated accumulator not sign-extended");

  a_flag_sticky_set: assert property (@(posedge clk) disable iff (!rstn)
    (op_valid && is_mac && flag_set) |=> ctrl_q[QMAC_FLAG_LSB + 32'($past(acc_select))])
    else $error("overflow flag not set");

  a_flag_never_clr: assert property (@(posedge clk) disable iff (!rstn)
    ($past(ctrl_q[QMAC_FLAG_MSB:QMAC_FLAG_LSB]) & ~ctrl_q[QMAC_FLAG_MSB:QMAC_FLAG_LSB]) == 4'h0)
    else $error("flag cleared by hardware");

  a_idx_keep_flags: assert property (@(posedge clk) disable iff (!rstn)
    (op_valid && op_code == QMAC_OP_INDEX_DEC) |=> $stable(ctrl_q))
    else $error("index decrement changed flags");

  a_plain_acc_add: assert property (@(posedge clk) disable iff (!rstn)
    (s_mac_acc0 and !is_sat) |=> acc_q[0] ==
      $past(acc_q[0]) + {{32{$past(prod_q31[31])}}, $past(prod_q31)})
    else $error("plain accumulate wrong");

  a_neg_one_clamp: assert property (@(posedge clk) disable iff (!rstn)
    (mul_a == QMAC_Q15_NEG_ONE && mul_b == QMAC_Q15_NEG_ONE) |-> prod_q31 == QMAC_Q31_MAX)
    else $error("minus one product not clamped");

  a_idx_reload: assert property (@(posedge clk) disable iff (!rstn)
    (op_valid && op_code == QMAC_OP_INDEX_DEC && first_source_reg == 32'h00000000)
      |=> result_valid && result_data == {16'h0000, $past(second_source_reg[23:8])})
    else $error("index reload wrong");

  a_idx_decrement: assert property (@(posedge clk) disable iff (!rstn)
    (op_valid && op_code == QMAC_OP_INDEX_DEC && first_source_reg != 32'h00000000)
      |=> result_data == $past(first_source_reg) - {24'h000000, $past(second_source_reg[7:0])})
    else $error("index decrement wrong");

  a_move_upper: assert property (@(posedge clk) disable iff (!rstn)
    (op_valid && op_code == QMAC_OP_MOVE_FROM_UPPER) |=> result_data == $past(acc_sel[63:32]))
    else $error("upper move wrong");

  a_move_lower: assert property (@(posedge clk) disable iff (!rstn)
    (op_valid && op_code == QMAC_OP_MOVE_FROM_LOWER) |=> result_data == $past(acc_sel[31:0]))
    else $error("lower move wrong");

  a_no_exception: assert property (@(posedge clk) disable iff (!rstn)
    !exc_value_raised)
    else $error("value exception raised");
endmodule : qmac_datapath

// ---- dv/qmac_pipe_model.sv ----
// issue-stage model of the host pipeline in front of the datapath
`timescale 1ns/1ns
module qmac_pipe_model
  import qmac_pkg::*;
(
  input  wire logic        go,
  input  qmac_op_e         op_in,
  input  wire logic [1:0]  sel_in,
  input  wire logic [31:0] a_in,
  input  wire logic [31:0] b_in,
  output logic             op_valid,
  output qmac_op_e         op_code,
  output logic      [1:0]  acc_select,
  output logic      [31:0] first_source_reg,
  output logic      [31:0] second_source_reg
);
  // ----
  // issue
  // ----
  // operands pass as software wrote them; their format is its own concern
  assign op_valid          = go;
  assign op_code           = op_in;
  assign acc_select        = sel_in;
  assign first_source_reg  = a_in;
  assign second_source_reg = b_in;
endmodule : qmac_pipe_model

// ---- dv/tb.sv ----
// self-checking bench for the q15 mac and index datapath
`timescale 1ns/1ns
module tb
  import qmac_pkg::*;
;
  logic        clk, rstn, go, op_valid, result_valid, exc_value_raised;
  qmac_op_e    op_in, op_code;
  logic [1:0]  sel_in, acc_select;
  logic [31:0] a_in, b_in, first_source_reg, second_source_reg, result_data;
  logic [31:0] signal_proc_control_reg, ctrl_m, r;
  logic [31:0] seed = 32'h00000007;
  logic [63:0] acc_m [4] = '{default: 64'h0};
  logic [31:0] exp_q [$];
  int          fails, checks_done;

  qmac_pipe_model i_qmac_pipe_model (.go(go), .op_in(op_in), .sel_in(sel_in), .a_in(a_in),
    .b_in(b_in), .op_valid(op_valid), .op_code(op_code), .acc_select(acc_select),
    .first_source_reg(first_source_reg), .second_source_reg(second_source_reg));
  qmac_datapath i_qmac_datapath (.clk(clk), .rstn(rstn), .op_valid(op_valid),
    .op_code(op_code), .acc_select(acc_select), .first_source_reg(first_source_reg),
    .second_source_reg(second_source_reg), .result_valid(result_valid),
    .result_data(result_data), .signal_proc_control_reg(signal_proc_control_reg),
    .exc_value_raised(exc_value_raised));

  // ----
  // helpers
  // ----
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic cmp(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // operands toggle while idle, so a stray take would show
  task automatic idle();
    go <= 1'b0;
    op_in <= QMAC_OP_MAC_LEFT_SAT;
    a_in <= rnd();
    b_in <= rnd();
    @(posedge clk);
  endtask : idle

  task automatic issue(qmac_op_e op, logic [1:0] s, logic [31:0] a, logic [31:0] b);
    logic [15:0] x, y;
    logic [31:0] p;
    logic [63:0] t;
    logic        ov, lf;
    op_in <= op;
    sel_in <= s;
    a_in <= a;
    b_in <= b;
    go <= 1'b1;
    @(posedge clk);
    lf = op inside {QMAC_OP_MAC_LEFT_PLAIN, QMAC_OP_MAC_LEFT_SAT};
    x = lf ? a[31:16] : a[15:0];
    y = lf ? b[31:16] : b[15:0];
    ov = (x == QMAC_Q15_NEG_ONE) && (y == QMAC_Q15_NEG_ONE);
    p = ov ? QMAC_Q31_MAX : 32'(int'($signed(x)) * int'($signed(y)) * 2);
    t = acc_m[s] + {{32{p[31]}}, p};
    case (op)
      QMAC_OP_MAC_LEFT_PLAIN, QMAC_OP_MAC_RIGHT_PLAIN: acc_m[s] = t;
      QMAC_OP_MAC_LEFT_SAT, QMAC_OP_MAC_RIGHT_SAT: begin
        if (t[32] != t[31]) begin
          t[31:0] = t[32] ? QMAC_Q31_MAX : QMAC_Q31_MIN;
          ov = 1'b1;
        end
        acc_m[s] = {{32{t[31]}}, t[31:0]};
      end
      QMAC_OP_MOVE_FROM_UPPER: exp_q.push_back(acc_m[s][63:32]);
      QMAC_OP_MOVE_FROM_LOWER: exp_q.push_back(acc_m[s][31:0]);
      QMAC_OP_MOVE_TO_UPPER: acc_m[s][63:32] = a;
      QMAC_OP_MOVE_TO_LOWER: acc_m[s][31:0] = a;
      QMAC_OP_INDEX_DEC: exp_q.push_back(a == 32'h0 ? {16'h0, b[23:8]} : a - {24'h0, b[7:0]});
      default: ;
    endcase
    if (ov && op inside {[QMAC_OP_MAC_LEFT_PLAIN:QMAC_OP_MAC_RIGHT_SAT]}) begin
      ctrl_m[QMAC_FLAG_LSB + s] = 1'b1;
    end
  endtask : issue

  task automatic dump(logic [1:0] s);
    issue(QMAC_OP_MOVE_FROM_UPPER, s, rnd(), rnd());
    issue(QMAC_OP_MOVE_FROM_LOWER, s, rnd(), rnd());
  endtask : dump

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // ----
  // clock, checking and sequence
  // ----
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(negedge clk) begin
    if (rstn === 1'b1) begin
      if (result_valid === 1'b1) begin
        cmp(result_data, exp_q.size() > 0 ? exp_q.pop_front() : 32'hXXXXXXXX);
      end
      cmp(signal_proc_control_reg, ctrl_m);
      cmp({31'h0, exc_value_raised}, 32'h0);
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    complete_run();
  end

  initial begin
    rstn = 1'b0;
    go = 1'b0;
    op_in = QMAC_OP_NONE;
    sel_in = 2'h0;
    a_in = 32'h0;
    b_in = 32'h0;
    ctrl_m = QMAC_CTRL_RST;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    idle();
    for (int s = 0; s < 4; s++) dump(2'(s));
    $display("test reset done");
    issue(QMAC_OP_INDEX_DEC, 2'h0, 32'h10, 32'h304);
    issue(QMAC_OP_INDEX_DEC, 2'h1, 32'h0, 32'hFFABCD07);
    issue(QMAC_OP_INDEX_DEC, 2'h3, 32'h2, 32'hFFFFFF);
    $display("test index done");
    for (int s = 0; s < 4; s++) begin
      issue(QMAC_OP_MOVE_TO_UPPER, 2'(s), 32'h0, 32'h0);
      issue(QMAC_OP_MOVE_TO_LOWER, 2'(s), 32'h7FFFFFF0, 32'h0);
      issue(QMAC_OP_MAC_RIGHT_SAT, 2'(s), 32'h4000, 32'h4000);
      dump(2'(s));
      issue(QMAC_OP_MOVE_TO_UPPER, 2'(s), 32'hFFFFFFFF, 32'h0);
      issue(QMAC_OP_MOVE_TO_LOWER, 2'(s), 32'h80000010, 32'h0);
      issue(QMAC_OP_MAC_LEFT_SAT, 2'(s), 32'hC0000000, 32'h40000000);
      dump(2'(s));
      issue(QMAC_OP_MAC_RIGHT_PLAIN, 2'(s), 32'h8000, 32'h8000);
      issue(QMAC_OP_MAC_LEFT_PLAIN, 2'(s), 32'h80000000, 32'h7FFF0000);
      dump(2'(s));
    end
    $display("test saturate done");
    repeat (300) begin
      r = rnd();
      issue(qmac_op_e'(4'(r % 10)), r[5:4], r[6] ? 32'h80008000 : rnd(),
            r[7] ? 32'h80008000 : rnd());
    end
    for (int s = 0; s < 4; s++) dump(2'(s));
    idle();
    idle();
    if (exp_q.size() != 0) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, 32'h0, exp_q.size());
    end
    $display("test random done");
    complete_run();
  end
endmodule : tb
